// ### include/lpcs_pkg.sv
package lpcs_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int CNT_W = 41;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_LP_CTRL = 8'h6e;
   localparam logic [7:0] IDX_GAIN_TRIM = 8'h7a;
   localparam logic [7:0] IDX_REF_TRIM = 8'h7c;
   localparam logic [7:0] IDX_CAL_MODE = 8'h70;
   localparam logic [7:0] IDX_LP_STATUS = 8'h71;

   // Low-power calibration control fields
   localparam int SLEEP_CODE_HI = 7;
   localparam int SLEEP_CODE_LO = 5;
   localparam int WAKE_CODE_HI = 4;
   localparam int WAKE_CODE_LO = 3;
   localparam int TRIG_SLEEP_BIT = 1;
   localparam int LOW_POWER_CAL_ENABLE_BIT = 0;

   // Calibration mode register fields
   localparam int BG_SEL_BIT = 0;
   localparam int TRIG_SRC_BIT = 1;
   localparam int SOFT_TRIG_BIT = 2;

   localparam int REF_TRIM_W = 4;

   localparam logic [7:0] LP_CTRL_RESET = 8'h88;
   localparam logic [7:0] TRIM_RESET = 8'h00;
   localparam logic SOFT_TRIG_RESET = 1'b1;

   // Shortest delay in device clock periods
   localparam longint SHORT_DLY_PERIODS = 1152;
   localparam longint TCLK_NS = 100;
   localparam longint PCLK_NS = 100;
   localparam logic [CNT_W-1:0] SHORT_DLY_CYC = CNT_W'((SHORT_DLY_PERIODS * TCLK_NS + PCLK_NS - 1)
                                                       / PCLK_NS);

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_SLEEP = 5'h02,
      ST_WAKE  = 5'h04,
      ST_CAL   = 5'h08,
      ST_ARM   = 5'h10
   } lpcs_state_t;

endpackage : lpcs_pkg

// ### hdl/lpcs_delay_timer.sv
`timescale 1ns/1ps
module lpcs_delay_timer #(
   parameter int WIDTH = lpcs_pkg::CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic clear,
   input wire logic [WIDTH-1:0] load_value,
   output logic expired
);
   import lpcs_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] count;
   } lpcs_timer_t;

   lpcs_timer_t t_reg;
   lpcs_timer_t t_next;

   // Expiry fires on the last counted cycle, so a load of N ends N cycles later
   // Load and clear stay out of this term: the scheduler decides its load from it
   assign expired = (t_reg.count == WIDTH'(1));

   always_comb begin
      t_next = t_reg;
      if (clear) begin
         t_next.count = '0;
      end else if (load) begin
         t_next.count = load_value;
      end else if (t_reg.count != '0) begin
         t_next.count = t_reg.count - WIDTH'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   timer_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      (load && !clear) |=> t_reg.count == $past(load_value))
      else $error("timer did not take load value");

   timer_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      (t_reg.count > WIDTH'(1) && !load && !clear) |=> t_reg.count == $past(t_reg.count) - 1)
      else $error("timer did not count down by one");

endmodule : lpcs_delay_timer

// ### hdl/lpcs_scheduler.sv
`timescale 1ns/1ps
//Contract
// - Sleep code times sleep in autonomous mode
// - Sleep codes 0..2 give listed periods
// - Sleep codes 3, 4 give listed periods
// - Sleep codes 5, 6 give listed periods
// - Wake code times settling before calibration
// - Wake codes 0, 1 give listed periods
// - Wake codes 2, 3 give listed periods
// - Trigger mode off: sleep from code
// - Trigger mode: sleep while trigger high; leaving idle, the core sleeps one cycle even with the trigger low
// - Enable acts only with background mode
// - Gain trim adjusts all cores
// - Reference trim readable, writable, factory loaded
// - Gain trim loaded from fuses at reset
// - Trigger source selects pin or software bit
module lpcs_scheduler #(
   parameter logic [lpcs_pkg::CNT_W-1:0] SLEEP_CYC_1 = 41'd4194432,
   parameter logic [lpcs_pkg::CNT_W-1:0] SLEEP_CYC_2 = 41'd33554560,
   parameter logic [lpcs_pkg::CNT_W-1:0] SLEEP_CYC_3 = 41'd268435584,
   parameter logic [lpcs_pkg::CNT_W-1:0] SLEEP_CYC_4 = 41'd2147483776,
   parameter logic [lpcs_pkg::CNT_W-1:0] SLEEP_CYC_5 = 41'd137438953600,
   parameter logic [lpcs_pkg::CNT_W-1:0] SLEEP_CYC_6 = 41'd1099511627904,
   parameter logic [lpcs_pkg::CNT_W-1:0] WAKE_CYC_1 = 41'd33554560,
   parameter logic [lpcs_pkg::CNT_W-1:0] WAKE_CYC_2 = 41'd268435584,
   parameter logic [lpcs_pkg::CNT_W-1:0] WAKE_CYC_3 = 41'd2147483776
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lpcs_pkg::ADDR_W-1:0] paddr,
   input wire logic [lpcs_pkg::DATA_W-1:0] pwdata,
   output logic [lpcs_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_cal_trigger_pin,
   input wire logic [7:0] fuse_gain_trim,
   input wire logic [lpcs_pkg::REF_TRIM_W-1:0] fuse_ref_trim,
   input wire logic cal_done,
   output logic core_sleep,
   output logic cal_start,
   output logic [7:0] gain_trim,
   output logic [lpcs_pkg::REF_TRIM_W-1:0] ref_trim
);
   import lpcs_pkg::*;

   typedef struct packed {
      logic [7:0] lp_ctrl;
      logic [7:0] gain;
      logic [7:0] ref_t;
      logic bg_sel;
      logic trig_src;
      logic soft_trig;
      lpcs_state_t st;
      logic [2:0] sync;
      logic trig_filt;
      logic fuse_pending;
      logic [DATA_W-1:0] rdata;
      logic ready;
      logic slverr;
      logic sleep;
      logic start;
   } lpcs_regs_t;

   lpcs_regs_t r_reg;
   lpcs_regs_t r_next;

   logic timer_load;
   logic timer_clear;
   logic [CNT_W-1:0] timer_value;
   logic expired;
   logic active;
   logic trig_mode;
   logic trig;
   logic access;
   logic [2:0] sleep_code;
   logic [1:0] wake_code;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      addr_hit = (a == {2'b00, idx, 2'b00});
   endfunction : addr_hit

   function automatic logic [CNT_W-1:0] sleep_cycles(input logic [2:0] code);
      unique case (code)
         3'd0: sleep_cycles = SHORT_DLY_CYC;
         3'd1: sleep_cycles = SLEEP_CYC_1;
         3'd2: sleep_cycles = SLEEP_CYC_2;
         3'd3: sleep_cycles = SLEEP_CYC_3;
         3'd4: sleep_cycles = SLEEP_CYC_4;
         3'd5: sleep_cycles = SLEEP_CYC_5;
         // Code 7 has no defined length; treated as the longest
         default: sleep_cycles = SLEEP_CYC_6;
      endcase
   endfunction : sleep_cycles

   function automatic logic [CNT_W-1:0] wake_cycles(input logic [1:0] code);
      unique case (code)
         2'd0: wake_cycles = SHORT_DLY_CYC;
         2'd1: wake_cycles = WAKE_CYC_1;
         2'd2: wake_cycles = WAKE_CYC_2;
         default: wake_cycles = WAKE_CYC_3;
      endcase
   endfunction : wake_cycles

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = addr_hit(a, IDX_LP_CTRL) || addr_hit(a, IDX_GAIN_TRIM) ||
               addr_hit(a, IDX_REF_TRIM) || addr_hit(a, IDX_CAL_MODE) ||
               addr_hit(a, IDX_LP_STATUS);
   endfunction : mapped

   lpcs_delay_timer #(
      .WIDTH(CNT_W)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .load(timer_load),
      .clear(timer_clear),
      .load_value(timer_value),
      .expired(expired)
   );

   assign sleep_code = r_reg.lp_ctrl[SLEEP_CODE_HI:SLEEP_CODE_LO];
   assign wake_code = r_reg.lp_ctrl[WAKE_CODE_HI:WAKE_CODE_LO];
   assign active = r_reg.bg_sel && r_reg.lp_ctrl[LOW_POWER_CAL_ENABLE_BIT];
   assign trig_mode = r_reg.lp_ctrl[TRIG_SLEEP_BIT];
   assign trig = r_reg.trig_src ? r_reg.trig_filt : r_reg.soft_trig;
   assign access = psel && penable;

   always_comb begin
      r_next = r_reg;
      r_next.ready = 1'b0;
      r_next.slverr = 1'b0;
      r_next.start = 1'b0;
      timer_load = 1'b0;
      timer_clear = 1'b0;
      timer_value = '0;

      // Pin filter: a change counts once the second and third stages agree
      r_next.sync = {r_reg.sync[1:0], external_cal_trigger_pin};
      if (r_reg.sync[1] == r_reg.sync[2]) begin
         r_next.trig_filt = r_reg.sync[2];
      end

      // One wait state: pready rises in the second access cycle
      if (access && !r_reg.ready) begin
         r_next.ready = 1'b1;
         r_next.slverr = !mapped(paddr);
         r_next.rdata = '0;
         if (!pwrite) begin
            if (addr_hit(paddr, IDX_LP_CTRL)) begin
               r_next.rdata[7:0] = r_reg.lp_ctrl;
            end else if (addr_hit(paddr, IDX_GAIN_TRIM)) begin
               r_next.rdata[7:0] = r_reg.gain;
            end else if (addr_hit(paddr, IDX_REF_TRIM)) begin
               r_next.rdata[7:0] = r_reg.ref_t;
            end else if (addr_hit(paddr, IDX_CAL_MODE)) begin
               r_next.rdata[SOFT_TRIG_BIT] = r_reg.soft_trig;
               r_next.rdata[TRIG_SRC_BIT] = r_reg.trig_src;
               r_next.rdata[BG_SEL_BIT] = r_reg.bg_sel;
            end else if (addr_hit(paddr, IDX_LP_STATUS)) begin
               r_next.rdata[7:0] = {trig, r_reg.sleep, 1'b0, r_reg.st};
            end
         end
      end

      // Writes land at the edge where pready is sampled high
      if (access && r_reg.ready && pwrite) begin
         if (addr_hit(paddr, IDX_LP_CTRL)) begin
            r_next.lp_ctrl = pwdata[7:0];
         end else if (addr_hit(paddr, IDX_GAIN_TRIM)) begin
            r_next.gain = pwdata[7:0];
         end else if (addr_hit(paddr, IDX_REF_TRIM)) begin
            r_next.ref_t = pwdata[7:0];
         end else if (addr_hit(paddr, IDX_CAL_MODE)) begin
            r_next.bg_sel = pwdata[BG_SEL_BIT];
            r_next.trig_src = pwdata[TRIG_SRC_BIT];
            r_next.soft_trig = pwdata[SOFT_TRIG_BIT];
         end
      end

      // Factory values arrive in the first cycle after reset release
      if (r_reg.fuse_pending) begin
         r_next.fuse_pending = 1'b0;
         r_next.gain = fuse_gain_trim;
         r_next.ref_t = {4'h0, fuse_ref_trim};
      end

      if (!active) begin
         r_next.st = ST_IDLE;
         r_next.sleep = 1'b0;
         timer_clear = 1'b1;
      end else begin
         unique case (r_reg.st)
            ST_IDLE, ST_ARM: begin
               // After a triggered calibration the core waits for the trigger to be high
               if (r_reg.st == ST_IDLE || !trig_mode || trig) begin
                  r_next.st = ST_SLEEP;
                  r_next.sleep = 1'b1;
                  timer_load = 1'b1;
                  timer_value = sleep_cycles(sleep_code);
               end
            end
            ST_SLEEP: begin
               // The sleep timer always runs; trigger mode simply ignores it
               if (trig_mode ? !trig : expired) begin
                  r_next.st = ST_WAKE;
                  r_next.sleep = 1'b0;
                  timer_load = 1'b1;
                  timer_value = wake_cycles(wake_code);
               end
            end
            ST_WAKE: begin
               if (expired) begin
                  r_next.st = ST_CAL;
                  r_next.start = 1'b1;
               end
            end
            ST_CAL: begin
               if (cal_done) begin
                  if (trig_mode) begin
                     r_next.st = ST_ARM;
                  end else begin
                     r_next.st = ST_SLEEP;
                     r_next.sleep = 1'b1;
                     timer_load = 1'b1;
                     timer_value = sleep_cycles(sleep_code);
                  end
               end
            end
            default: begin
               r_next.st = ST_IDLE;
               r_next.sleep = 1'b0;
               timer_clear = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '{lp_ctrl: LP_CTRL_RESET, gain: TRIM_RESET, ref_t: TRIM_RESET,
                    bg_sel: 1'b0, trig_src: 1'b0, soft_trig: SOFT_TRIG_RESET,
                    st: ST_IDLE, sync: 3'h0, trig_filt: 1'b0, fuse_pending: 1'b1,
                    rdata: '0, ready: 1'b0, slverr: 1'b0, sleep: 1'b0, start: 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata = r_reg.rdata;
   assign pready = r_reg.ready;
   assign pslverr = r_reg.slverr;
   assign core_sleep = r_reg.sleep;
   assign cal_start = r_reg.start;
   assign gain_trim = r_reg.gain;
   assign ref_trim = r_reg.ref_t[REF_TRIM_W-1:0];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sleep_enter_a: assert property (
      (r_reg.st == ST_IDLE && active) |=> (r_reg.st == ST_SLEEP && core_sleep))
      else $error("active block did not enter sleep");

   short_sleep_a: assert property (
      (timer_load && r_next.st == ST_SLEEP && sleep_code == 3'd0) |-> timer_value == 41'd1152)
      else $error("sleep code 0 loaded wrong count");

   default_sleep_a: assert property (
      (timer_load && r_next.st == ST_SLEEP && sleep_code == 3'd4) |-> timer_value == SLEEP_CYC_4)
      else $error("sleep code 4 loaded wrong count");

   long_sleep_a: assert property (
      (timer_load && r_next.st == ST_SLEEP && sleep_code == 3'd6) |-> timer_value == SLEEP_CYC_6)
      else $error("sleep code 6 loaded wrong count");

   wake_short_a: assert property (
      (timer_load && r_next.st == ST_WAKE && wake_code == 2'd0) |-> timer_value == 41'd1152)
      else $error("wake code 0 loaded wrong count");

   wake_long_a: assert property (
      (timer_load && r_next.st == ST_WAKE && wake_code == 2'd3) |-> timer_value == WAKE_CYC_3)
      else $error("wake code 3 loaded wrong count");

   wake_start_a: assert property (
      (active && r_reg.st == ST_WAKE && expired)
      |=> (cal_start && r_reg.st == ST_CAL) ##1 !cal_start)
      else $error("calibration did not start after settling");

   auto_hold_a: assert property (
      (active && r_reg.st == ST_SLEEP && !trig_mode && !expired) |=> core_sleep)
      else $error("core woke before sleep timer expired");

   trig_wake_a: assert property (
      (active && r_reg.st == ST_SLEEP && trig_mode && !trig)
      |=> (!core_sleep && r_reg.st == ST_WAKE))
      else $error("low trigger did not wake core");

   idle_force_a: assert property (
      (!r_reg.bg_sel) |=> (!core_sleep && r_reg.st == ST_IDLE))
      else $error("low-power schedule ran without background mode");

   gain_write_a: assert property (
      (access && pready && pwrite && addr_hit(paddr, IDX_GAIN_TRIM) && !r_reg.fuse_pending)
      |=> gain_trim == $past(pwdata[7:0]))
      else $error("gain trim write lost");

   ref_read_a: assert property (
      (access && !pready && !pwrite && addr_hit(paddr, IDX_REF_TRIM) && !r_reg.fuse_pending)
      |=> (pready && prdata[7:0] == $past(r_reg.ref_t)))
      else $error("reference trim read back wrong");

   fuse_load_a: assert property (
      r_reg.fuse_pending |=> (gain_trim == $past(fuse_gain_trim) && !r_reg.fuse_pending))
      else $error("gain trim not loaded from fuses");

   soft_src_a: assert property (
      (active && r_reg.st == ST_SLEEP && trig_mode && !r_reg.trig_src && r_reg.soft_trig)
      |=> core_sleep)
      else $error("software trigger high did not hold sleep");

endmodule : lpcs_scheduler

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import lpcs_pkg::*;
   // Short stand-ins for the long counts keep the run small; code 0 stays at full length
   localparam int S1 = 21, S2 = 25, S3 = 29, S4 = 33, S5 = 37, S6 = 41;
   localparam int W1 = 17, W2 = 23, W3 = 31;
   localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'({IDX_LP_CTRL, 2'b00});
   localparam logic [ADDR_W-1:0] A_GAIN = ADDR_W'({IDX_GAIN_TRIM, 2'b00});
   localparam logic [ADDR_W-1:0] A_REF = ADDR_W'({IDX_REF_TRIM, 2'b00});
   localparam logic [ADDR_W-1:0] A_MODE = ADDR_W'({IDX_CAL_MODE, 2'b00});
   localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'({IDX_LP_STATUS, 2'b00});
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready, pslverr, core_sleep, cal_start, cal_done = 1'b0, trig_pin = 1'b0;
   logic [7:0] gain_trim;
   logic [REF_TRIM_W-1:0] ref_trim;
   logic [7:0] fuse_gain = 8'h5a;
   logic [REF_TRIM_W-1:0] fuse_ref = 4'h9;
   int n_mismatch = 0, compares = 0;
   int sleep_tab[7];
   int wake_tab[4];

   always #50 pclk = ~pclk;

   lpcs_scheduler #(
      .SLEEP_CYC_1(CNT_W'(S1)), .SLEEP_CYC_2(CNT_W'(S2)), .SLEEP_CYC_3(CNT_W'(S3)),
      .SLEEP_CYC_4(CNT_W'(S4)), .SLEEP_CYC_5(CNT_W'(S5)), .SLEEP_CYC_6(CNT_W'(S6)),
      .WAKE_CYC_1(CNT_W'(W1)), .WAKE_CYC_2(CNT_W'(W2)), .WAKE_CYC_3(CNT_W'(W3))
   ) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_cal_trigger_pin(trig_pin), .fuse_gain_trim(fuse_gain),
      .fuse_ref_trim(fuse_ref), .cal_done(cal_done), .core_sleep(core_sleep),
      .cal_start(cal_start), .gain_trim(gain_trim), .ref_trim(ref_trim)
   );

   task automatic end_sim();
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic chk_cnt(input int got, input int exp, input string what);
      compares++;
      if (got != exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s cycles %0d exp %0d", $time, what, got, exp);
      end
   endtask : chk_cnt

   task automatic limit(input int n, input int lim);
      if (n >= lim) begin
         n_mismatch++;
         $display("MISMATCH t=%0t wait limit reached", $time);
         end_sim();
      end
   endtask : limit

   // Entered just after a rising edge; leaves one idle edge so psel is never set twice at once
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      limit(n, 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, {24'h0, d}, rd, err);
      chk({31'h0, err}, 32'h0, "write error flag");
   endtask : wr

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd, exp, what);
   endtask : rdc

   // Counts edges until core_sleep (sel 0) or cal_start (sel 1) is sampled at lvl
   task automatic cnt(input int sel, input logic lvl, input int lim, output int n);
      n = 0;
      while ((sel == 0 ? core_sleep : cal_start) !== lvl && n < lim) begin
         @(posedge pclk);
         n++;
      end
      limit(n, lim);
   endtask : cnt

   task automatic done_pulse();
      cal_done <= 1'b1;
      @(posedge pclk);
      cal_done <= 1'b0;
      @(posedge pclk);
   endtask : done_pulse

   task automatic measure(input int ns, input int nw);
      int n;
      cnt(0, 1'b1, 60, n);
      cnt(0, 1'b0, 3000, n);
      chk_cnt(n, ns, "sleep length");
      cnt(1, 1'b1, 3000, n);
      chk_cnt(n, nw, "wake settle length");
      @(posedge pclk);
      chk({31'h0, cal_start}, 32'h0, "start pulse width");
   endtask : measure

   task automatic t_reset();
      rdc(A_CTRL, 32'h88, "ctrl reset");
      rdc(A_GAIN, 32'h5a, "gain fuse load");
      rdc(A_REF, 32'h09, "ref fuse load");
      rdc(A_MODE, 32'h04, "mode reset");
      rdc(A_STAT, 32'h81, "idle status");
      chk({24'h0, gain_trim}, 32'h5a, "gain out");
      chk({28'h0, ref_trim}, 32'h9, "ref out");
   endtask : t_reset

   task automatic t_regs();
      logic [31:0] rd;
      logic err;
      wr(A_GAIN, 8'ha5);
      chk({24'h0, gain_trim}, 32'ha5, "gain out written");
      apb(1'b1, A_GAIN, 32'hffffff3c, rd, err);
      rdc(A_GAIN, 32'h3c, "gain upper bits dropped");
      wr(A_REF, 8'h06);
      chk({28'h0, ref_trim}, 32'h6, "ref out written");
      rdc(A_REF, 32'h06, "ref readback");
      apb(1'b1, 12'h1bc, 32'h000000ff, rd, err);
      chk({31'h0, err}, 32'h1, "unmapped write error");
      apb(1'b0, 12'h1bc, 32'h0, rd, err);
      chk({31'h0, err}, 32'h1, "unmapped read error");
      chk(rd, 32'h0, "unmapped read data");
      rdc(A_CTRL, 32'h88, "ctrl untouched");
   endtask : t_regs

   task automatic t_gate();
      wr(A_CTRL, 8'h89);
      repeat (60) @(posedge pclk);
      chk({31'h0, core_sleep}, 32'h0, "enable without background mode");
      rdc(A_STAT, 32'h81, "still idle");
      wr(A_CTRL, 8'h88);
   endtask : t_gate

   task automatic t_auto();
      logic [7:0] c;
      wr(A_MODE, 8'h05);
      for (int i = 0; i < 7; i++) begin
         c = {i[2:0], 2'(i % 4), 3'b001};
         wr(A_CTRL, c);
         if (i > 0) begin
            done_pulse();
         end
         measure(sleep_tab[i], wake_tab[i % 4]);
      end
      wr(A_CTRL, 8'h89);
      done_pulse();
      repeat (5) @(posedge pclk);
      chk({31'h0, core_sleep}, 32'h1, "sleeping again");
      wr(A_CTRL, 8'h88);
      // The return edge is the one that drops the core out of sleep; look one edge later
      @(posedge pclk);
      chk({31'h0, core_sleep}, 32'h0, "disable mid sleep");
      rdc(A_STAT, 32'h81, "back to idle");
   endtask : t_auto

   task automatic t_trig();
      int n;
      wr(A_CTRL, 8'h8b);
      cnt(0, 1'b1, 60, n);
      repeat (S4 + 20) @(posedge pclk);
      chk({31'h0, core_sleep}, 32'h1, "held by soft trigger");
      wr(A_MODE, 8'h01);
      cnt(0, 1'b0, 10, n);
      cnt(1, 1'b1, 3000, n);
      chk_cnt(n, W1, "settle after trigger wake");
      done_pulse();
      repeat (20) @(posedge pclk);
      chk({31'h0, core_sleep}, 32'h0, "armed awake while trigger low");
      // Soft bit high with pin source selected must not put the core to sleep
      wr(A_MODE, 8'h07);
      repeat (10) @(posedge pclk);
      chk({31'h0, core_sleep}, 32'h0, "soft bit ignored");
      trig_pin <= 1'b1;
      cnt(0, 1'b1, 8, n);
      rdc(A_STAT, 32'hc2, "sleep status on pin");
      wr(A_MODE, 8'h03);
      chk({31'h0, core_sleep}, 32'h1, "pin holds sleep");
      trig_pin <= 1'b0;
      cnt(0, 1'b0, 8, n);
      cnt(1, 1'b1, 3000, n);
      chk_cnt(n, W1, "settle after pin wake");
      done_pulse();
   endtask : t_trig

   initial begin
      sleep_tab = '{int'(SHORT_DLY_CYC), S1, S2, S3, S4, S5, S6};
      wake_tab = '{int'(SHORT_DLY_CYC), W1, W2, W3};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      t_reset();
      t_regs();
      t_gate();
      t_auto();
      t_trig();
      end_sim();
   end
endmodule : tb_top
